// ===== src/tpc_channel.sv
// Purpose: One timer channel: status/control, capture, compare and PWM pin logic
// Assumes: Main counter lives outside and reports value, direction and change pulse
// Notes: APB slave with no wait states; outputs registered
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tpc_channel
  import tpc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Main counter status
  input wire logic [CNT_W-1:0] i_count,
  input wire logic [CNT_W-1:0] i_modulo,
  input wire logic i_count_tick,
  input wire logic i_count_down,
  // Counter and value latch control
  output logic o_center_mode,
  output logic o_value_latch_reset,
  // Channel pin
  input wire logic i_pin,
  output logic o_pin,
  output logic o_pin_oe,
  output logic o_pin_timer_own,
  // Interrupts
  output logic o_chan_irq,
  output logic o_irq
);

  tpc_csc_type csc;
  logic center_pwm_select;
  logic [CNT_W-1:0] chan_value;
  logic irq_status;
  logic irq_mask;
  logic clear_armed;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic pin_level;
  tpc_mode_type mode;
  logic acc;
  logic wr;
  logic rd;
  logic csc_wr;
  logic csc_rd;
  logic rise;
  logic fall;
  logic edge_hit;
  logic match;
  logic duty_extreme;
  logic chan_event;
  logic period_start;
  logic next_pin;
  logic [31:0] next_rdata;
  logic next_err;

  // Completed APB access and its decode
  assign acc = i_psel && i_penable && o_pready;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign csc_wr = wr && (i_paddr == TPC_OFS_CSC);
  assign csc_rd = rd && (i_paddr == TPC_OFS_CSC);

  // Mode decode
  assign mode = tpc_decode_mode(center_pwm_select, csc.mode_sel_b,
                                csc.mode_sel_a);

  // Pin edge detection on synchronised input
  assign rise = pin_sync && !pin_prev;
  assign fall = !pin_sync && pin_prev;
  always_comb begin
    case (csc.edge_level)
      TPC_ELS_01: edge_hit = rise;
      TPC_ELS_10: edge_hit = fall;
      TPC_ELS_11: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // Counter match and zero/full duty detection
  assign match = i_count_tick && (i_count == chan_value);
  assign duty_extreme = (chan_value == '0) ||
                        ((i_modulo != '0) && (chan_value > i_modulo));
  assign period_start = i_count_tick && (i_count == '0);

  // Channel event source per mode
  always_comb begin
    case (mode)
      TPC_MODE_CAPTURE: chan_event = edge_hit;
      TPC_MODE_COMPARE: chan_event = match;
      TPC_MODE_EDGE_PWM,
      TPC_MODE_CENTER_PWM: chan_event = match && !duty_extreme;
      default: chan_event = 1'b0;
    endcase
  end

  // APB ready: no wait state, high in the first access cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable && !o_pready;
    end
  end

  // Read data and error selection
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (i_paddr)
      TPC_OFS_CSC: next_rdata[7:2] = csc;
      TPC_OFS_TIMER_CTRL: next_rdata[TPC_BIT_CENTER] = center_pwm_select;
      TPC_OFS_VALUE: next_rdata[CNT_W-1:0] = chan_value;
      TPC_OFS_IRQ_STATUS: next_rdata[TPC_BIT_EVENT] = irq_status;
      TPC_OFS_IRQ_MASK: next_rdata[TPC_BIT_EVENT] = irq_mask;
      default: next_err = 1'b1;
    endcase
  end

  // Registered read data and error, captured at setup
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
      o_pslverr <= next_err;
    end else if (acc) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  // Channel event flag with read-then-write-zero clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      csc.flag <= TPC_RST_BIT;
      clear_armed <= 1'b0;
    end else if (chan_event) begin
      csc.flag <= 1'b1;
      clear_armed <= 1'b0;
    end else if (csc_wr) begin
      if (clear_armed && !i_pwdata[TPC_BIT_FLAG]) begin
        csc.flag <= 1'b0;
      end
      clear_armed <= 1'b0;
    end else if (csc_rd && csc.flag) begin
      clear_armed <= 1'b1;
    end
  end

  // Control fields of the channel register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      csc.irq_en <= TPC_RST_BIT;
      csc.mode_sel_b <= TPC_RST_BIT;
      csc.mode_sel_a <= TPC_RST_BIT;
      csc.edge_level <= TPC_ELS_OFF;
    end else if (csc_wr) begin
      csc.irq_en <= i_pwdata[TPC_BIT_IE];
      csc.mode_sel_b <= i_pwdata[TPC_BIT_MSB];
      csc.mode_sel_a <= i_pwdata[TPC_BIT_MSA];
      csc.edge_level <= i_pwdata[TPC_BIT_ELSB:TPC_BIT_ELSA];
    end
  end

  // Timer-wide center select
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      center_pwm_select <= TPC_RST_BIT;
    end else if (wr && (i_paddr == TPC_OFS_TIMER_CTRL)) begin
      center_pwm_select <= i_pwdata[TPC_BIT_CENTER];
    end
  end

  // Channel value: captured in capture mode, software writes ignored there
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chan_value <= TPC_RST_VALUE[CNT_W-1:0];
    end else if (mode == TPC_MODE_CAPTURE) begin
      if (edge_hit) begin
        chan_value <= i_count;
      end
    end else if (wr && (i_paddr == TPC_OFS_VALUE)) begin
      chan_value <= i_pwdata[CNT_W-1:0];
    end
  end

  // Sticky interrupt status, write one clears, event wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_status <= TPC_RST_BIT;
    end else if (chan_event) begin
      irq_status <= 1'b1;
    end else if (wr && (i_paddr == TPC_OFS_IRQ_STATUS) && i_pwdata[TPC_BIT_EVENT]) begin
      irq_status <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_mask <= TPC_RST_BIT;
    end else if (wr && (i_paddr == TPC_OFS_IRQ_MASK)) begin
      irq_mask <= i_pwdata[TPC_BIT_EVENT];
    end
  end

  // Registered interrupt outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_chan_irq <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_chan_irq <= csc.flag && csc.irq_en;
      o_irq <= irq_status && irq_mask;
    end
  end

  // Pin synchroniser; prev tracks always so a settled pin gives no edge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Output level for compare and PWM modes
  always_comb begin
    next_pin = pin_level;
    case (mode)
      TPC_MODE_COMPARE: begin
        if (match) begin
          case (csc.edge_level)
            TPC_ELS_01: next_pin = !pin_level;
            TPC_ELS_10: next_pin = 1'b0;
            TPC_ELS_11: next_pin = 1'b1;
            default: next_pin = pin_level;
          endcase
        end
      end
      TPC_MODE_EDGE_PWM: begin
        if (chan_value == '0) begin
          next_pin = csc.edge_level[0];
        end else if (match) begin
          next_pin = csc.edge_level[0];
        end else if (period_start) begin
          next_pin = !csc.edge_level[0];
        end
      end
      TPC_MODE_CENTER_PWM: begin
        if (chan_value == '0) begin
          next_pin = csc.edge_level[0];
        end else if (match) begin
          next_pin = i_count_down ? !csc.edge_level[0]
                                  : csc.edge_level[0];
        end
      end
      default: next_pin = pin_level;
    endcase
  end

  // Pin level register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= next_pin;
    end
  end

  // Pin drivers and ownership
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
      o_pin_timer_own <= 1'b0;
    end else begin
      o_pin <= next_pin;
      o_pin_oe <= (csc.edge_level != TPC_ELS_OFF) &&
                  (mode != TPC_MODE_CAPTURE);
      o_pin_timer_own <= (csc.edge_level != TPC_ELS_OFF);
    end
  end

  // Counter mode and value latch reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_center_mode <= 1'b0;
      o_value_latch_reset <= 1'b0;
    end else begin
      o_center_mode <= center_pwm_select;
      o_value_latch_reset <= csc_wr;
    end
  end

endmodule

`default_nettype wire

// ===== common/tpc_pkg.sv
// Purpose: Shared constants and types for the timer channel control block
// Assumes: 32-bit APB, one word per register, 125 MHz clock
// Notes: Functional notes below
// Functional notes
// - Input capture sets the event flag on the selected pin edge
// - Compare and PWM modes set the flag on counter match
// - PWM at zero or full duty never sets the flag
// - Channel irq request while flag and enable both set
// - Flag clears by read-while-set then write zero; writing one is ignored
// - New event between read and write restarts the clear sequence
// - Reset clears flag and interrupt enable
// - Without center select, mode B one means edge PWM
// - Without center select and B zero, A picks capture or compare
// - Edge/level code 00 releases the pin in every mode
// - Capture codes: 01 rising, 10 falling, 11 both edges
// - Compare codes: 01 toggle, 10 drive low, 11 drive high
// - Edge PWM: 10 high-true clear on match, X1 low-true set
// - Center PWM: 10 clear on up match, X1 set on up match
// - Center select forces center PWM and up/down counting
// - Any channel status/control register write resets the value byte latch
package tpc_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] TPC_OFS_CSC = 8'h00;
  localparam logic [7:0] TPC_OFS_TIMER_CTRL = 8'h04;
  localparam logic [7:0] TPC_OFS_VALUE = 8'h08;
  localparam logic [7:0] TPC_OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] TPC_OFS_IRQ_MASK = 8'h10;

  // Field positions in the channel status/control register
  localparam int TPC_BIT_FLAG = 7;
  localparam int TPC_BIT_IE = 6;
  localparam int TPC_BIT_MSB = 5;
  localparam int TPC_BIT_MSA = 4;
  localparam int TPC_BIT_ELSB = 3;
  localparam int TPC_BIT_ELSA = 2;

  // Field positions in timer control and interrupt registers
  localparam int TPC_BIT_CENTER = 0;
  localparam int TPC_BIT_EVENT = 0;

  // Reset values
  localparam logic [15:0] TPC_RST_VALUE = 16'h0000;
  localparam logic TPC_RST_BIT = 1'b0;

  // Edge/level codes
  localparam logic [1:0] TPC_ELS_OFF = 2'h0;
  localparam logic [1:0] TPC_ELS_01 = 2'h1;
  localparam logic [1:0] TPC_ELS_10 = 2'h2;
  localparam logic [1:0] TPC_ELS_11 = 2'h3;

  // Channel control fields
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic mode_sel_b;
    logic mode_sel_a;
    logic [1:0] edge_level;
  } tpc_csc_type;

  // Channel operating modes
  typedef enum logic [1:0] {
    TPC_MODE_CAPTURE,
    TPC_MODE_COMPARE,
    TPC_MODE_EDGE_PWM,
    TPC_MODE_CENTER_PWM
  } tpc_mode_type;

  // Mode decode from center select and the two mode bits
  function automatic tpc_mode_type tpc_decode_mode(input logic center,
                                                   input logic msb,
                                                   input logic msa);
    tpc_mode_type m;
    if (center) begin
      m = TPC_MODE_CENTER_PWM;
    end else if (msb) begin
      m = TPC_MODE_EDGE_PWM;
    end else if (msa) begin
      m = TPC_MODE_COMPARE;
    end else begin
      m = TPC_MODE_CAPTURE;
    end
    return m;
  endfunction

endpackage

// ===== test/tpc_pin_model.sv
// Purpose: External signal source on the channel pin
// Assumes: Bench clock drives it
// Notes: Level lands one clock after the request
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
  // Clock and level request
  input wire logic i_clk,
  input wire logic i_level,
  // Pin drive
  output logic o_line
);
  // Level held stable between requests
  initial o_line = 1'b0;
  always @(posedge i_clk) o_line <= i_level;
endmodule
`default_nettype wire

// ===== test/tpc_channel_assertions.sv
// Purpose: Port checks of the timer channel
// Assumes: One clock, async active high reset
// Notes: Bound to every channel instance
`timescale 1ns/1ps
`default_nettype none
module tpc_channel_assertions
  import tpc_pkg::*;
(
  // Clock, reset, bus
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic i_count_tick,
  // Watched outputs
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_center_mode,
  input wire logic o_value_latch_reset,
  input wire logic o_pin,
  input wire logic o_pin_oe,
  input wire logic o_pin_timer_own,
  input wire logic o_chan_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Completed writes
  wire logic wr_any = i_psel && i_penable && i_pwrite && o_pready;
  wire logic wr_csc = wr_any && (i_paddr == TPC_OFS_CSC);
  wire logic wr_ctl = wr_any && (i_paddr == TPC_OFS_TIMER_CTRL);
  property p_ready;
    i_psel && !i_penable |=> o_pready ##1 !o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_slverr;
    o_pslverr |-> o_pready && i_penable;
  endproperty
  a_slverr: assert property (p_slverr) else $error("slverr outside access");
  property p_oe;
    o_pin_oe |-> o_pin_timer_own;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven while released");
  property p_latch;
    wr_csc |-> ##[1:2] o_value_latch_reset;
  endproperty
  a_latch: assert property (p_latch) else $error("no latch reset");
  property p_rst;
    $fell(i_sys_rst) |-> !o_chan_irq && !o_pin_oe && !o_center_mode;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_clear;
    $fell(o_chan_irq) |-> $past(wr_csc) || $past(wr_csc, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("irq fell without write");
  property p_center;
    $changed(o_center_mode) |-> $past(wr_ctl) || $past(wr_ctl, 2);
  endproperty
  a_center: assert property (p_center) else $error("center changed alone");
  property p_pin;
    $changed(o_pin) |-> $past(i_count_tick) || $past(wr_any) || $past(wr_any, 2);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved without cause");
  // Main scenarios
  c_irq: cover property ($rose(o_chan_irq));
  c_pin: cover property (o_pin_oe && $rose(o_pin));
  c_ctr: cover property ($rose(o_center_mode));
endmodule
bind tpc_channel tpc_channel_assertions chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_count_tick(i_count_tick), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_center_mode(o_center_mode), .o_value_latch_reset(o_value_latch_reset),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_timer_own(o_pin_timer_own),
  .o_chan_irq(o_chan_irq));
`default_nettype wire

// ===== test/timer_channel_mode_control_test.sv
// Purpose: Self-checking bench of the timer channel
// Assumes: Counter modelled by ticks, modulo free running
// Notes: Bus replies checked against a queue
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_control_test;
  import tpc_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0, down = 1'b0, level = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, c;
  logic [15:0] count = 16'h0, v, cap;
  logic exp_pin;
  logic [1:0] ord [3] = '{2'h2, 2'h1, 2'h3};
  logic [31:0] pc [2] = '{32'h28, 32'h34};
  wire logic pready, pslverr, center, lreset, pin_out, pin_oe, pin_own, chan_irq, irq, ext;
  wire logic [31:0] prdata;
  wire logic pin_wire = pin_oe ? pin_out : ext;
  logic [32:0] expq [$];
  int mismatches = 0, checks_done = 0, cycles = 0;
  int seed = 32'h1173df6e;
  always #4 i_clk = ~i_clk;
  tpc_channel dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_count(count), .i_modulo(16'h0),
    .i_count_tick(tick), .i_count_down(down), .o_center_mode(center),
    .o_value_latch_reset(lreset), .i_pin(pin_wire), .o_pin(pin_out), .o_pin_oe(pin_oe),
    .o_pin_timer_own(pin_own), .o_chan_irq(chan_irq), .o_irq(irq));
  tpc_pin_model ext_u (.i_clk(i_clk), .i_level(level), .o_line(ext));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bus cycle, expected reply queued
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back(e);
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  // One counter step
  task automatic ev(input logic [15:0] n, input logic dn);
    @(posedge i_clk);
    count <= n;
    tick <= 1'b1;
    down <= dn;
    @(posedge i_clk);
    tick <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic pin_is(input logic e);
    check({31'h0, pin_oe, pin_out}, {31'h0, 1'b1, e});
  endtask
  // Reply monitor and hang limit
  always @(posedge i_clk) begin
    cycles++;
    if (pready === 1'b1) check({pslverr, prdata}, expq.pop_front());
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(TPC_OFS_CSC, 32'h0);
    apb(1'b1, 8'h40, 32'h0, {1'b1, 32'h0});
    cap = 16'($random(seed));
    count <= cap;
    for (int k = 1; k < 4; k++) begin
      c = 32'h40 | 32'(k << 2);
      wr(TPC_OFS_CSC, c);
      level <= 1'b1;
      repeat (8) @(posedge i_clk);
      rd(TPC_OFS_CSC, c | (k[0] ? 32'h80 : 32'h0));
      level <= 1'b0;
      repeat (8) @(posedge i_clk);
      rd(TPC_OFS_CSC, c | 32'h80);
      check({32'h0, chan_irq}, 33'h1);
      wr(TPC_OFS_CSC, c);
      rd(TPC_OFS_CSC, c);
    end
    wr(TPC_OFS_VALUE, 32'h1234);
    rd(TPC_OFS_VALUE, {16'h0, cap});
    wr(TPC_OFS_CSC, 32'h90);
    rd(TPC_OFS_CSC, 32'h10);
    check({31'h0, pin_oe, pin_own}, 33'h0);
    check({32'h0, irq}, 33'h0);
    wr(TPC_OFS_IRQ_MASK, 32'h1);
    rd(TPC_OFS_IRQ_STATUS, 32'h1);
    check({32'h0, irq}, 33'h1);
    wr(TPC_OFS_IRQ_STATUS, 32'h1);
    rd(TPC_OFS_IRQ_STATUS, 32'h0);
    check({32'h0, irq}, 33'h0);
    // Output compare codes
    v = 16'($random(seed)) | 16'h0001;
    wr(TPC_OFS_CSC, 32'h18);
    wr(TPC_OFS_VALUE, {16'h0, v});
    rd(TPC_OFS_VALUE, {16'h0, v});
    exp_pin = 1'b0;
    foreach (ord[j]) begin
      c = 32'h10 | (32'(ord[j]) << 2);
      wr(TPC_OFS_CSC, c);
      ev(v, 1'b0);
      exp_pin = (ord[j] == 2'h1) ? ~exp_pin : ord[j][0];
      pin_is(exp_pin);
      rd(TPC_OFS_CSC, c | 32'h80);
      ev(v, 1'b0);
      wr(TPC_OFS_CSC, c);
      rd(TPC_OFS_CSC, c | 32'h80);
      if (ord[j] == 2'h1) exp_pin = ~exp_pin;
    end
    // Edge PWM polarities
    foreach (pc[j]) begin
      wr(TPC_OFS_CSC, pc[j]);
      ev(16'h0, 1'b0);
      pin_is(~pc[j][2]);
      ev(v, 1'b0);
      pin_is(pc[j][2]);
      rd(TPC_OFS_CSC, pc[j] | 32'h80);
    end
    wr(TPC_OFS_CSC, 32'h34);
    wr(TPC_OFS_VALUE, 32'h0);
    ev(16'h0, 1'b0);
    rd(TPC_OFS_CSC, 32'h34);
    pin_is(1'b1);
    // Center PWM, mode bits overridden
    wr(TPC_OFS_VALUE, {16'h0, v});
    wr(TPC_OFS_TIMER_CTRL, 32'h1);
    repeat (2) @(posedge i_clk);
    check({32'h0, center}, 33'h1);
    foreach (pc[j]) begin
      c = pc[j] & 32'h0c;
      wr(TPC_OFS_CSC, c);
      ev(v, 1'b1);
      pin_is(~c[2]);
      ev(v, 1'b0);
      pin_is(c[2]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
